// *** design/dtm_pkg.sv ***
// Constants and types shared by the dual 8-bit cascadable timer
// Notes on behaviour
// (R1) Counter clears on match A, B or pin
// (R2) Output pin toggles duty via compare matches
// (R3) 16-bit mode: even upper, odd lower byte
// (R4) Odd channel counts even channel's compare match A
// (R5) Separate match A, B, overflow interrupts per channel
// (R6) Even channel events go to event link
// (R7) Linked event: start, count or restart even channel; in 16-bit mode the code ignores linked events
// (R8) Match A/B interrupts may trigger transfer controller
// (R9) Baud clock for serial port from matches
// (R10) Remote-control receiver clock when receiver present
// (R11) Module stop halts the whole unit except the external clear inputs
// (R12) Internal clock: divide by 1..8192 prescaler taps
// (R13) External count clock may drive the counter
// (R14) 16-bit wrap advances upper; overflow at full wrap
package dtm_pkg;

    localparam int PRESC_W = 13;

    // Count clock select codes
    localparam logic [2:0] CS_DIV1    = 3'h0;
    localparam logic [2:0] CS_DIV2    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV32   = 3'h3;
    localparam logic [2:0] CS_DIV64   = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_DIV8192 = 3'h6;
    localparam logic [2:0] CS_EXT     = 3'h7;

    // Prescaler tap widths (divisor = 2**width)
    localparam logic [3:0] SH_DIV1    = 4'h0;
    localparam logic [3:0] SH_DIV2    = 4'h1;
    localparam logic [3:0] SH_DIV8    = 4'h3;
    localparam logic [3:0] SH_DIV32   = 4'h5;
    localparam logic [3:0] SH_DIV64   = 4'h6;
    localparam logic [3:0] SH_DIV1024 = 4'ha;
    localparam logic [3:0] SH_DIV8192 = 4'hd;

    // Counter clear source codes
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_CMA  = 2'h1;
    localparam logic [1:0] CLR_CMB  = 2'h2;
    localparam logic [1:0] CLR_EXT  = 2'h3;

    // Reset values and counter maximum
    localparam logic [7:0]         CNT_RST   = 8'h00;
    localparam logic [7:0]         CNT_MAX   = 8'hff;
    localparam logic [PRESC_W-1:0] PRESC_RST = 13'h0000;

    typedef enum logic [2:0] {
        MODE_IND = 3'b001,
        MODE_16  = 3'b010,
        MODE_CMC = 3'b100
    } dtm_mode_t;

    typedef enum logic [3:0] {
        ACT_NONE    = 4'b0001,
        ACT_START   = 4'b0010,
        ACT_COUNT   = 4'b0100,
        ACT_RESTART = 4'b1000
    } dtm_act_t;

endpackage

// *** design/dtm_chan.sv ***
// One 8-bit counter channel with two comparators
`timescale 1ns/100ps
module dtm_chan
(
    input  wire logic       clk_sys,  // System clock
    input  wire logic       arst_n,   // Async reset
    input  wire logic       inc,      // Count one step
    input  wire logic       clr,      // Synchronous clear
    input  wire logic [7:0] cmp_a,    // Compare value A
    input  wire logic [7:0] cmp_b,    // Compare value B
    output logic      [7:0] cnt_ff,   // Counter value
    output logic            eq_a,     // Counter equals A
    output logic            eq_b,     // Counter equals B
    output logic            at_max    // Counter at all ones
);

    logic [7:0] nxt_cnt;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (clr)
        begin
            nxt_cnt = dtm_pkg::CNT_RST;
        end
        else if (inc)
        begin
            nxt_cnt = cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_ff <= dtm_pkg::CNT_RST;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign eq_a   = (cnt_ff == cmp_a);
    assign eq_b   = (cnt_ff == cmp_b);
    assign at_max = (cnt_ff == dtm_pkg::CNT_MAX);

    property p_clr_wins;
        @(posedge clk_sys) disable iff (!arst_n)
        clr |=> (cnt_ff == dtm_pkg::CNT_RST);
    endproperty
    a_clr_wins: assert property (p_clr_wins) else $error("counter not cleared"); // [R1]

endmodule

// *** design/dtm_unit.sv ***
// Two-channel timer unit: prescaler, cascade, matches, outputs
`timescale 1ns/100ps
module dtm_unit
#(
    parameter bit REMOTE_CONTROL_RECEIVER_PRESENT = 1'b1
)
(
    input  wire logic              clk_sys,      // System clock, 20 MHz
    input  wire logic              arst_n,       // Async reset
    input  wire logic              mod_stop,     // Module stop
    input  dtm_pkg::dtm_mode_t     mode,         // Cascade mode
    input  dtm_pkg::dtm_act_t      evt_act,      // Linked event action
    input  wire logic              evt_in,       // Linked event pulse
    input  wire logic [1:0][2:0]   clk_sel,      // Count clock select
    input  wire logic [1:0][1:0]   clr_sel,      // Clear source select
    input  wire logic [1:0][7:0]   cmp_a,        // Compare values A
    input  wire logic [1:0][7:0]   cmp_b,        // Compare values B
    input  wire logic [1:0]        ext_clk,      // External count clocks
    input  wire logic [1:0]        ext_rst,      // External clear inputs
    input  wire logic [1:0]        dtc_en,       // Transfer trigger enable
    output logic      [1:0][7:0]   cnt_ff,       // Counter values
    output logic      [1:0]        tmo_ff,       // Timer output pins
    output logic      [1:0]        irq_cma_ff,   // Match A interrupts
    output logic      [1:0]        irq_cmb_ff,   // Match B interrupts
    output logic      [1:0]        irq_ovf_ff,   // Overflow interrupts
    output logic      [1:0]        dtc_req_ff,   // Transfer requests
    output logic                   elc_cma_ff,   // Even match A event
    output logic                   elc_cmb_ff,   // Even match B event
    output logic                   elc_ovf_ff,   // Even overflow event
    output logic                   baud_clk_ff,  // Serial baud clock
    output logic                   remote_control_receiver_clk_ff   // Remote receiver clock
);

    //--------------------------------------------------------------
    // Prescaler and clock selection
    //--------------------------------------------------------------
    logic [dtm_pkg::PRESC_W-1:0] presc_ff;
    logic [1:0]                  ext_prev_ff;
    logic [1:0]                  tick;
    logic [1:0]                  inc;
    logic [1:0]                  clr;
    logic [1:0]                  clrm;
    logic [1:0]                  cm_a;
    logic [1:0]                  cm_b;
    logic [1:0]                  ovf;
    logic [1:0]                  eq_a;
    logic [1:0]                  eq_b;
    logic [1:0]                  at_max;
    logic                        run_ff;
    logic                        run_ok;
    logic                        restart;
    logic                        is16;
    logic                        cm16_a;
    logic                        cm16_b;

    function automatic logic presc_hit(input logic [2:0] sel,
                                       input logic [dtm_pkg::PRESC_W-1:0] p);
        logic [3:0]                  sh;
        logic [dtm_pkg::PRESC_W-1:0] mask;
        case (sel)
            dtm_pkg::CS_DIV1:    sh = dtm_pkg::SH_DIV1;
            dtm_pkg::CS_DIV2:    sh = dtm_pkg::SH_DIV2;
            dtm_pkg::CS_DIV8:    sh = dtm_pkg::SH_DIV8;
            dtm_pkg::CS_DIV32:   sh = dtm_pkg::SH_DIV32;
            dtm_pkg::CS_DIV64:   sh = dtm_pkg::SH_DIV64;
            dtm_pkg::CS_DIV1024: sh = dtm_pkg::SH_DIV1024;
            default:             sh = dtm_pkg::SH_DIV8192;
        endcase
        mask = ~({dtm_pkg::PRESC_W{1'b1}} << sh);
        return ((p & mask) == mask);
    endfunction

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            presc_ff <= dtm_pkg::PRESC_RST;
        end
        else if (!mod_stop)
        begin
            presc_ff <= presc_ff + 13'h0001; // [R11] [R12]
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ext_prev_ff <= 2'h0;
        end
        else
        begin
            ext_prev_ff <= ext_clk;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_tick
            // Rising edge of external clock or prescaler tap
            assign tick[gi] = !mod_stop && ((clk_sel[gi] == dtm_pkg::CS_EXT)
                ? (ext_clk[gi] && !ext_prev_ff[gi])                     // [R13]
                : presc_hit(clk_sel[gi], presc_ff));                    // [R12]
        end
    endgenerate

    //--------------------------------------------------------------
    // Linked event handling for the even channel
    //--------------------------------------------------------------
    assign is16    = (mode == dtm_pkg::MODE_16);
    assign restart = evt_in && !mod_stop && (evt_act == dtm_pkg::ACT_RESTART) && !is16; // [R11]
    assign run_ok  = (evt_act == dtm_pkg::ACT_NONE) || (evt_act == dtm_pkg::ACT_COUNT)
                     || run_ff;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            run_ff <= 1'b0;
        end
        else if (evt_in && !mod_stop && ((evt_act == dtm_pkg::ACT_START)
                 || (evt_act == dtm_pkg::ACT_RESTART)))
        begin
            run_ff <= 1'b1; // [R7]
        end
    end

    //--------------------------------------------------------------
    // Count, match, clear and overflow decoding
    //--------------------------------------------------------------
    always_comb
    begin
        inc[1] = !mod_stop && ((mode == dtm_pkg::MODE_CMC)
                 ? cm_a[0] : tick[1]);                                  // [R4] [R11]
        if (is16)
        begin
            inc[0] = inc[1] && at_max[1];                               // [R3] [R14]
        end
        else if (evt_act == dtm_pkg::ACT_COUNT)
        begin
            inc[0] = !mod_stop && evt_in;                               // [R7]
        end
        else
        begin
            inc[0] = tick[0] && run_ok;                                 // [R7]
        end
    end

    assign cm16_a = inc[1] && eq_a[0] && eq_a[1];
    assign cm16_b = inc[1] && eq_b[0] && eq_b[1];

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            cm_a[i] = is16 ? cm16_a : (inc[i] && eq_a[i]);
            cm_b[i] = is16 ? cm16_b : (inc[i] && eq_b[i]);
            clrm[i] = ((clr_sel[i] == dtm_pkg::CLR_CMA) && cm_a[i])
                   || ((clr_sel[i] == dtm_pkg::CLR_CMB) && cm_b[i])
                   || ((clr_sel[i] == dtm_pkg::CLR_EXT) && ext_rst[i]); // [R1]
        end
        clr[0] = is16 ? clrm[0] : (clrm[0] || restart);                 // [R1] [R7]
        clr[1] = is16 ? clrm[0] : clrm[1];
        ovf[0] = inc[0] && at_max[0] && !clr[0];                        // [R14]
        ovf[1] = inc[1] && at_max[1] && !clr[1] && !is16;               // [R14]
    end

    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_chan
            dtm_chan u_chan
            (
                .clk_sys (clk_sys),
                .arst_n  (arst_n),
                .inc     (inc[gi]),
                .clr     (clr[gi]),
                .cmp_a   (cmp_a[gi]),
                .cmp_b   (cmp_b[gi]),
                .cnt_ff  (cnt_ff[gi]),
                .eq_a    (eq_a[gi]),
                .eq_b    (eq_b[gi]),
                .at_max  (at_max[gi])
            );
        end
    endgenerate

    //--------------------------------------------------------------
    // Pin outputs, requests and derived clocks
    //--------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tmo_ff <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (cm_b[i])
                begin
                    tmo_ff[i] <= 1'b0; // [R2]
                end
                else if (cm_a[i])
                begin
                    tmo_ff[i] <= 1'b1; // [R2]
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_cma_ff <= 2'h0;
            irq_cmb_ff <= 2'h0;
            irq_ovf_ff <= 2'h0;
            dtc_req_ff <= 2'h0;
        end
        else
        begin
            irq_cma_ff <= cm_a;                                          // [R5]
            irq_cmb_ff <= cm_b;                                          // [R5]
            irq_ovf_ff <= ovf;                                           // [R5]
            dtc_req_ff <= dtc_en & (cm_a | cm_b);                        // [R8]
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            elc_cma_ff <= 1'b0;
            elc_cmb_ff <= 1'b0;
            elc_ovf_ff <= 1'b0;
        end
        else
        begin
            elc_cma_ff <= cm_a[0]; // [R6]
            elc_cmb_ff <= cm_b[0]; // [R6]
            elc_ovf_ff <= ovf[0];  // [R6]
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            baud_clk_ff <= 1'b0;
            remote_control_receiver_clk_ff <= 1'b0;
        end
        else
        begin
            if (cm_a[1])
            begin
                baud_clk_ff <= !baud_clk_ff; // [R9]
            end
            if (REMOTE_CONTROL_RECEIVER_PRESENT && cm_b[1])
            begin
                remote_control_receiver_clk_ff <= !remote_control_receiver_clk_ff; // [R10]
            end
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    property p_clr_cma;
        @(posedge clk_sys) disable iff (!arst_n)
        (!is16 && clr_sel[0] == dtm_pkg::CLR_CMA && cm_a[0]) |=> (cnt_ff[0] == 8'h00);
    endproperty
    a_clr_cma: assert property (p_clr_cma) else $error("no clear on match A"); // [R1]

    property p_pwm;
        @(posedge clk_sys) disable iff (!arst_n)
        (cm_a[0] && !cm_b[0]) |=> tmo_ff[0];
    endproperty
    a_pwm: assert property (p_pwm) else $error("timer output wrong"); // [R2]

    property p_pwm_clr;
        @(posedge clk_sys) disable iff (!arst_n)
        cm_b[0] |=> !tmo_ff[0];
    endproperty
    a_pwm_clr: assert property (p_pwm_clr) else $error("timer output not cleared"); // [R2]

    property p_cascade;
        @(posedge clk_sys) disable iff (!arst_n)
        (is16 && inc[1] && at_max[1] && !clr[0])
            |=> (cnt_ff[0] == $past(cnt_ff[0]) + 8'h01) && (cnt_ff[1] == 8'h00);
    endproperty
    a_cascade: assert property (p_cascade) else $error("upper byte not advanced"); // [R3]

    property p_cmc;
        @(posedge clk_sys) disable iff (!arst_n)
        (mode == dtm_pkg::MODE_CMC && cm_a[0] && !clr[1] && !mod_stop)
            |=> (cnt_ff[1] == $past(cnt_ff[1]) + 8'h01);
    endproperty
    a_cmc: assert property (p_cmc) else $error("match count missed"); // [R4]

    property p_irq;
        @(posedge clk_sys) disable iff (!arst_n)
        ovf[1] |=> irq_ovf_ff[1] ##1 !irq_ovf_ff[1] || $past(ovf[1]);
    endproperty
    a_irq: assert property (p_irq) else $error("overflow request wrong"); // [R5]

    property p_elc;
        @(posedge clk_sys) disable iff (!arst_n)
        cm_b[0] |=> elc_cmb_ff && irq_cmb_ff[0];
    endproperty
    a_elc: assert property (p_elc) else $error("event output missing"); // [R6]

    property p_restart;
        @(posedge clk_sys) disable iff (!arst_n)
        restart |=> (cnt_ff[0] == 8'h00) && run_ff;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not done"); // [R7]

    property p_dtc;
        @(posedge clk_sys) disable iff (!arst_n)
        (dtc_en[0] && cm_a[0]) |=> dtc_req_ff[0];
    endproperty
    a_dtc: assert property (p_dtc) else $error("transfer request missing"); // [R8]

    property p_baud;
        @(posedge clk_sys) disable iff (!arst_n)
        cm_a[1] |=> (baud_clk_ff != $past(baud_clk_ff));
    endproperty
    a_baud: assert property (p_baud) else $error("baud clock not toggled"); // [R9]

    property p_stop;
        @(posedge clk_sys) disable iff (!arst_n)
        (mod_stop && !ext_rst[0] && !ext_rst[1]) |=> $stable(cnt_ff) && $stable(presc_ff);
    endproperty
    a_stop: assert property (p_stop) else $error("counting in module stop"); // [R11]

    property p_ovf16;
        @(posedge clk_sys) disable iff (!arst_n)
        (is16 && inc[1] && at_max[1] && at_max[0] && !clr[0]) |=> irq_ovf_ff[0] && !irq_ovf_ff[1];
    endproperty
    a_ovf16: assert property (p_ovf16) else $error("16-bit overflow wrong"); // [R14]

endmodule

// *** verification/dtm_far_model.sv ***
// Far-side model: interrupt, event link and transfer controllers, count pins
`timescale 1ns/100ps
module dtm_far_model
(
    input  wire logic        clk_sys,   // System clock
    input  wire logic        arst_n,    // Async reset
    input  wire logic [11:0] req,       // Request pulses from the unit
    input  wire logic        evt_go,    // Command one linked event per cycle
    input  wire logic        ext_run,   // Run the external count clock
    output logic      [15:0] hits [12], // Rising edges seen per request
    output logic             evt_in,    // Linked event pulse
    output logic             ext_clk    // External count clock
);
    logic [11:0] req_ff;
    logic [1:0]  div_ff;

    // Tally of requests taken by the controllers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_ff <= 12'h000;
            for (int i = 0; i < 12; i++) hits[i] <= 16'h0000;
        end
        else
        begin
            req_ff <= req;
            for (int i = 0; i < 12; i++)
                if (req[i] && !req_ff[i]) hits[i] <= hits[i] + 16'h0001;
        end
    end

    // Event link: one pulse per commanded cycle
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n) evt_in <= 1'b0;
        else evt_in <= evt_go;
    end

    // External clock, period 6 cycles, still when not running
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_ff  <= 2'h0;
            ext_clk <= 1'b0;
        end
        else if (!ext_run)
        begin
            div_ff  <= 2'h0;
            ext_clk <= 1'b0;
        end
        else
        begin
            div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
            if (div_ff == 2'h2) ext_clk <= ~ext_clk;
        end
    end
endmodule

// *** verification/dual_8bit_cascadable_timer_tb_top.sv ***
// Self-checking testbench of the two-channel timer unit
`timescale 1ns/100ps
module dual_8bit_cascadable_timer_tb_top;
    logic                 clk_sys, arst_n, mod_stop, evt_in, evt_go, ext_run, ext_clk_m;
    dtm_pkg::dtm_mode_t   mode;
    dtm_pkg::dtm_act_t    evt_act;
    logic [1:0][2:0]      clk_sel;
    logic [1:0][1:0]      clr_sel;
    logic [1:0][7:0]      cmp_a, cmp_b, cnt_ff;
    logic [1:0]           ext_rst, dtc_en, tmo_ff, irq_cma_ff, irq_cmb_ff, irq_ovf_ff, dtc_req_ff;
    logic                 elc_cma_ff, elc_cmb_ff, elc_ovf_ff, baud_clk_ff, remote_control_receiver_clk_ff;
    logic [11:0]          sig;
    logic [15:0]          hits [12];
    int                   n_errors, n_checks;

    assign sig = {remote_control_receiver_clk_ff, baud_clk_ff, irq_ovf_ff[1], irq_cma_ff[1], tmo_ff[0], elc_ovf_ff,
                  elc_cmb_ff, elc_cma_ff, dtc_req_ff[0], irq_ovf_ff[0], irq_cmb_ff[0],
                  irq_cma_ff[0]};

    dtm_unit dtm_unit_inst (.clk_sys(clk_sys), .arst_n(arst_n), .mod_stop(mod_stop),
        .mode(mode), .evt_act(evt_act), .evt_in(evt_in), .clk_sel(clk_sel), .clr_sel(clr_sel),
        .cmp_a(cmp_a), .cmp_b(cmp_b), .ext_clk({ext_clk_m, ext_clk_m}), .ext_rst(ext_rst),
        .dtc_en(dtc_en), .cnt_ff(cnt_ff), .tmo_ff(tmo_ff), .irq_cma_ff(irq_cma_ff),
        .irq_cmb_ff(irq_cmb_ff), .irq_ovf_ff(irq_ovf_ff), .dtc_req_ff(dtc_req_ff),
        .elc_cma_ff(elc_cma_ff), .elc_cmb_ff(elc_cmb_ff), .elc_ovf_ff(elc_ovf_ff),
        .baud_clk_ff(baud_clk_ff), .remote_control_receiver_clk_ff(remote_control_receiver_clk_ff));

    dtm_far_model dtm_far_model_inst (.clk_sys(clk_sys), .arst_n(arst_n), .req(sig),
        .evt_go(evt_go), .ext_run(ext_run), .hits(hits), .evt_in(evt_in), .ext_clk(ext_clk_m));

    // ----------------------------------------
    // Clock and helpers
    // ----------------------------------------
    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic do_reset;
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
    endtask

    task automatic chan(input int c, input logic [2:0] cs, input logic [1:0] cl,
                        input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_sys);
        clk_sel[c] <= cs;
        clr_sel[c] <= cl;
        cmp_a[c]   <= a;
        cmp_b[c]   <= b;
    endtask

    task automatic rise(input int i, output int n);
        n = 0;
        while (sig[i] !== 1'b0 && n < 40000)
        begin
            @(negedge clk_sys);
            n++;
        end
        while (sig[i] !== 1'b1 && n < 40000)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // Cycles from one rising edge of a watched output to the next
    task automatic gap(input int i, input int e);
        int n;
        rise(i, n);
        rise(i, n);
        check(n, e);
    endtask

    task automatic hi(input int i, input int e);
        int n;
        rise(i, n);
        n = 0;
        while (sig[i] === 1'b1 && n < 40000)
        begin
            @(negedge clk_sys);
            n++;
        end
        check(n, e);
    endtask

    task automatic pulse(input int n);
        @(posedge clk_sys);
        evt_go <= 1'b1;
        repeat (n) @(posedge clk_sys);
        evt_go <= 1'b0;
    endtask

    task automatic until16(input logic [15:0] v);
        int n;
        n = 0;
        while ({cnt_ff[0], cnt_ff[1]} !== v && n < 70000)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_match;
        int n;
        do_reset();
        chan(0, dtm_pkg::CS_DIV1, dtm_pkg::CLR_CMA, 8'h02, 8'h01);
        chan(1, dtm_pkg::CS_DIV1, dtm_pkg::CLR_CMA, 8'h03, 8'h01);
        gap(0, 3);
        gap(3, 3);
        gap(4, 3);
        hi(7, 2);
        gap(8, 4);
        gap(10, 8);
        gap(11, 8);
        n = 0;
        while (irq_cmb_ff[1] !== 1'b1 && n < 10)
        begin
            @(negedge clk_sys);
            n++;
        end
        check({irq_cmb_ff[1], dtc_req_ff[1], tmo_ff[1]}, 3'b110);
        $display("test match done");
    endtask

    task automatic t_clr;
        chan(0, dtm_pkg::CS_DIV1, dtm_pkg::CLR_CMB, 8'h09, 8'h04);
        chan(1, dtm_pkg::CS_DIV1, dtm_pkg::CLR_NONE, 8'h00, 8'h00);
        gap(1, 5);
        gap(5, 5);
        gap(9, 256);
        chan(0, dtm_pkg::CS_DIV1, dtm_pkg::CLR_NONE, 8'h09, 8'h04);
        gap(2, 256);
        gap(6, 256);
        $display("test clear done");
    endtask

    task automatic t_presc;
        logic [2:0] cs [6] = '{dtm_pkg::CS_DIV2, dtm_pkg::CS_DIV8, dtm_pkg::CS_DIV32,
                               dtm_pkg::CS_DIV64, dtm_pkg::CS_DIV1024, dtm_pkg::CS_DIV8192};
        int         dv [6] = '{2, 8, 32, 64, 1024, 8192};
        for (int k = 0; k < 6; k++)
        begin
            chan(0, cs[k], dtm_pkg::CLR_CMA, 8'h00, 8'h00);
            gap(0, dv[k]);
        end
        chan(0, dtm_pkg::CS_EXT, dtm_pkg::CLR_CMA, 8'h01, 8'h00);
        ext_run <= 1'b1;
        gap(0, 12);
        ext_run <= 1'b0;
        $display("test prescaler done");
    endtask

    task automatic t_stop;
        logic [7:0] a;
        chan(0, dtm_pkg::CS_DIV1, dtm_pkg::CLR_EXT, 8'h80, 8'h80);
        ext_rst <= 2'b01;
        repeat (6) @(negedge clk_sys);
        check(cnt_ff[0], 8'h00);
        @(posedge clk_sys);
        ext_rst  <= 2'b00;
        mod_stop <= 1'b1;
        repeat (3) @(negedge clk_sys);
        a = cnt_ff[0];
        repeat (20) @(negedge clk_sys);
        check(cnt_ff[0], a);
        @(posedge clk_sys);
        mod_stop <= 1'b0;
        repeat (4) @(negedge clk_sys);
        check(cnt_ff[0] != a, 1'b1);
        $display("test stop done");
    endtask

    task automatic t_evt;
        logic [7:0] a;
        chan(0, dtm_pkg::CS_DIV1, dtm_pkg::CLR_NONE, 8'hf0, 8'hf0);
        evt_act <= dtm_pkg::ACT_START;
        do_reset();
        repeat (5) @(negedge clk_sys);
        check(cnt_ff[0], 8'h00);
        pulse(1);
        repeat (3) @(negedge clk_sys);
        a = cnt_ff[0];
        repeat (10) @(negedge clk_sys);
        check(8'(cnt_ff[0] - a), 8'h0a);
        @(posedge clk_sys);
        evt_act <= dtm_pkg::ACT_COUNT;
        repeat (3) @(negedge clk_sys);
        a = cnt_ff[0];
        pulse(3);
        repeat (4) @(negedge clk_sys);
        check(8'(cnt_ff[0] - a), 8'h03);
        @(posedge clk_sys);
        evt_act <= dtm_pkg::ACT_RESTART;
        pulse(1);
        repeat (2) @(negedge clk_sys);
        check(cnt_ff[0] < 8'h04, 1'b1);
        @(posedge clk_sys);
        evt_act <= dtm_pkg::ACT_NONE;
        $display("test events done");
    endtask

    task automatic t_cmc;
        int n;
        @(posedge clk_sys);
        mode <= dtm_pkg::MODE_CMC;
        chan(0, dtm_pkg::CS_DIV1, dtm_pkg::CLR_CMA, 8'h03, 8'h80);
        chan(1, dtm_pkg::CS_DIV8192, dtm_pkg::CLR_NONE, 8'hf0, 8'hf0);
        do_reset();
        n = 0;
        while (hits[0] !== 16'h0005 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
        check(cnt_ff[1], 8'h05);
        $display("test match count done");
    endtask

    task automatic t_16;
        @(posedge clk_sys);
        mode <= dtm_pkg::MODE_16;
        chan(0, dtm_pkg::CS_DIV1, dtm_pkg::CLR_NONE, 8'h12, 8'h56);
        chan(1, dtm_pkg::CS_DIV1, dtm_pkg::CLR_NONE, 8'h34, 8'h78);
        do_reset();
        until16(16'h00ff);
        @(negedge clk_sys);
        check({cnt_ff[0], cnt_ff[1]}, 16'h0100);
        until16(16'hffff);
        check(hits[0], 16'h0001);
        check(hits[8], 16'h0001);
        repeat (3) @(negedge clk_sys);
        check(hits[2], 16'h0001);
        check(hits[6], 16'h0001);
        check(hits[9], 16'h0000);
        $display("test cascade done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        n_errors = 0;
        n_checks = 0;
        arst_n   = 1'b0;
        mod_stop = 1'b0;
        mode     = dtm_pkg::MODE_IND;
        evt_act  = dtm_pkg::ACT_NONE;
        evt_go   = 1'b0;
        ext_run  = 1'b0;
        clk_sel  = '0;
        clr_sel  = '0;
        cmp_a    = '0;
        cmp_b    = '0;
        ext_rst  = 2'b00;
        dtc_en   = 2'b11;
        t_match();
        t_clr();
        t_presc();
        t_stop();
        t_evt();
        t_cmc();
        t_16();
        stop_test();
    end

    initial
    begin
        repeat (98000) @(posedge clk_sys);
        n_errors++;
        stop_test();
    end
endmodule
